// ===== rtl/wdt_ctrl.sv
// CPU-side end: turns software commands into watchdog register sequences
`timescale 1ns/1ps
`default_nettype none
module wdt_ctrl
   import wdt_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   wdt_if.host bus,
   input wire logic [ADDR_W-1:0] sw_addr,
   input wire logic [DATA_W-1:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [DATA_W-1:0] sw_rdata,
   input wire logic cpu_hold,
   input wire logic nmi_service_done,
   output logic cpu_reset
);
   import wdt_pkg::*;
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_DIS_CLR = 3'b001,
      S_DIS_EN0 = 3'b010,
      S_DIS_KEY = 3'b011,
      S_DIS_DONE = 3'b100
   } wdt_seq_t;
   wdt_seq_t st_q, st_d;
   logic imf_q, imf_d;
   logic [1:0] per_q, per_d;
   logic act_q, act_d;
   logic en_q, en_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] wdata_q, wdata_d;
   logic wr_q, wr_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic [7:0] stat;

   assign stat = (bus.reset_request ? ST_WDT_RST : 8'h00) |
      (bus.watchdog_nmi_request ? ST_WDT_NMI : 8'h00) | (en_q ? ST_WDT_RUN : ST_WDT_DIS);

   always_comb
   begin
      st_d = st_q;
      imf_d = imf_q;
      per_d = per_q;
      act_d = act_q;
      en_d = en_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      wr_d = 1'b0;
      rdata_d = (sw_rd && sw_addr == CMD_STATUS) ? stat : 8'h00;
      case (st_q)
         S_IDLE:
         begin
            if (sw_wr)
            begin
               wr_d = 1'b1;
               case (sw_addr)
                  CMD_PERIOD:
                  begin
                     per_d = sw_wdata[1:0];
                     addr_d = SETUP_OFFSET;
                     wdata_d = {4'h0, en_q, sw_wdata[1:0], act_q};
                  end
                  CMD_ACTION:
                  begin
                     act_d = sw_wdata[0];
                     addr_d = SETUP_OFFSET;
                     wdata_d = {4'h0, en_q, per_q, sw_wdata[0]};
                  end
                  CMD_CLEAR:
                  begin
                     addr_d = KEY_OFFSET;
                     wdata_d = CLEAR_CODE;
                  end
                  CMD_ENABLE:
                  begin
                     en_d = 1'b1;
                     addr_d = SETUP_OFFSET;
                     wdata_d = {4'h0, 1'b1, per_q, act_q};
                  end
                  CMD_DISABLE:
                  begin
                     imf_d = 1'b0;
                     wr_d = 1'b0;
                     st_d = S_DIS_CLR;
                  end
                  default: wr_d = 1'b0;
               endcase
            end
         end
         S_DIS_CLR:
         begin
            wr_d = 1'b1;
            addr_d = KEY_OFFSET;
            wdata_d = CLEAR_CODE;
            st_d = S_DIS_EN0;
         end
         S_DIS_EN0:
         begin
            wr_d = 1'b1;
            en_d = 1'b0;
            addr_d = SETUP_OFFSET;
            wdata_d = {4'h0, 1'b0, per_q, act_q};
            st_d = S_DIS_KEY;
         end
         S_DIS_KEY:
         begin
            wr_d = 1'b1;
            addr_d = KEY_OFFSET;
            wdata_d = DISABLE_CODE;
            st_d = S_DIS_DONE;
         end
         S_DIS_DONE:
         begin
            imf_d = 1'b1;
            st_d = S_IDLE;
         end
         default: st_d = S_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         st_q <= S_IDLE;
         imf_q <= 1'b1;
         per_q <= SETUP_RESET[PER_LSB +: 2];
         act_q <= SETUP_RESET[ACT_BIT];
         en_q <= SETUP_RESET[EN_BIT];
         addr_q <= '0;
         wdata_q <= '0;
         wr_q <= 1'b0;
         rdata_q <= '0;
      end
      else
      begin
         st_q <= st_d;
         imf_q <= imf_d;
         per_q <= per_d;
         act_q <= act_d;
         en_q <= en_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         wr_q <= wr_d;
         rdata_q <= rdata_d;
      end
   end

   assign bus.addr = addr_q;
   assign bus.wdata = wdata_q;
   assign bus.wr = wr_q;
   // Never reads the write-only registers
   assign bus.rd = 1'b0;
   assign bus.hold = cpu_hold;
   assign bus.irq_master_flag = imf_q;
   assign bus.nmi_ack = nmi_service_done;
   assign sw_rdata = rdata_q;
   assign cpu_reset = bus.reset_request;
endmodule : wdt_ctrl
`default_nettype wire

// ===== common/wdt_pkg.sv
// Package: watchdog register map, key codes and timing constants
package wdt_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] SETUP_OFFSET = 16'h0034;
   localparam logic [ADDR_W-1:0] KEY_OFFSET = 16'h0035;
   localparam int EN_BIT = 3;
   localparam int PER_LSB = 1;
   localparam int ACT_BIT = 0;
   localparam logic [DATA_W-1:0] SETUP_RESET = 8'h09;
   localparam logic [DATA_W-1:0] CLEAR_CODE = 8'h4E;
   localparam logic [DATA_W-1:0] DISABLE_CODE = 8'hB1;
   localparam logic ACT_RESET = 1'b1;
   localparam logic ACT_NMI = 1'b0;
   // Detection period 2^N: exponent for period code 00, step per code
   localparam int PER_EXP_BASE = 25;
   localparam int PER_EXP_STEP = 2;
   // Binary counter is two stages; the divider supplies the rest
   localparam int BIN_STAGES = 2;
   localparam real FC_MHZ = 200.0;
   localparam real RESET_MAX_FC = 24.0;
   // Longest reset rounds down to whole cycles
   localparam int RESET_CYCLES = int'($floor(RESET_MAX_FC));
   // Read data of write-only registers: arbitrary filler
   localparam logic [DATA_W-1:0] UNDEF_READ = 8'hFF;
   localparam logic [7:0] ST_WDT_DIS = 8'h00;
   localparam logic [7:0] ST_WDT_RUN = 8'h01;
   localparam logic [7:0] ST_WDT_NMI = 8'h02;
   localparam logic [7:0] ST_WDT_RST = 8'h04;
   localparam logic [ADDR_W-1:0] CMD_PERIOD = 16'h0000;
   localparam logic [ADDR_W-1:0] CMD_ACTION = 16'h0001;
   localparam logic [ADDR_W-1:0] CMD_CLEAR = 16'h0002;
   localparam logic [ADDR_W-1:0] CMD_DISABLE = 16'h0003;
   localparam logic [ADDR_W-1:0] CMD_ENABLE = 16'h0004;
   localparam logic [ADDR_W-1:0] CMD_STATUS = 16'h0005;
endpackage : wdt_pkg

// ===== common/wdt_if.sv
// Interface: CPU-side register port and watchdog outputs
`timescale 1ns/1ps
`default_nettype none
interface wdt_if;
   import wdt_pkg::*;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic wr;
   logic rd;
   logic [DATA_W-1:0] rdata;
   logic hold;
   logic irq_master_flag;
   logic watchdog_nmi_request;
   logic nmi_ack;
   logic reset_request;
   modport device (input addr, input wdata, input wr, input rd, output rdata, input hold,
      input irq_master_flag, output watchdog_nmi_request, input nmi_ack, output reset_request);
   modport host (output addr, output wdata, output wr, output rd, input rdata, output hold,
      output irq_master_flag, input watchdog_nmi_request, output nmi_ack, input reset_request);
endinterface : wdt_if
`default_nettype wire

// ===== rtl/wdt_pulse_stretch.sv
// Holds a one-cycle trigger high for a fixed number of cycles
`timescale 1ns/1ps
`default_nettype none
module wdt_pulse_stretch #(
   parameter int LEN = 24
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic trig,
   output logic pulse
);
   localparam int CW = $clog2(LEN + 1);
   logic [CW-1:0] cnt_q, cnt_d;
   initial
   begin
      if (LEN < 1) $error("LEN must be at least 1");
   end
   always_comb
   begin
      cnt_d = cnt_q;
      if (trig)
         cnt_d = CW'(LEN);
      else if (cnt_q != '0)
         cnt_d = cnt_q - 1'b1;
   end
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end
   assign pulse = (cnt_q != '0);
endmodule : wdt_pulse_stretch
`default_nettype wire

// ===== rtl/wdt_core.sv
// Watchdog device end: setup and key registers, divider, binary counter
// Summary of operation
// - Reset: reset action selected, watchdog running
// - Interrupt action, once chosen, sticks until reset
// - Overflow with reset action: reset pulse, 24 cycles max
// - Overflow with interrupt action raises watchdog interrupt
// - Watchdog interrupt ignores the interrupt master flag
// - New watchdog interrupt preempts; prior held pending
// - Period code picks 2^25/23/21/19, doubled option
// - Clear code clears binary counter, not divider
// - Overflow after clear may come at 3/4 period
// - Software clears within 3/4 period, not in interrupts
// - Never clear counter from an interrupt task
// - Disable code works only when enable bit 0
// - Disable order: mask, clear, enable 0, disable code
// - Disabled watchdog holds its counters cleared
// - Counting pauses in STOP and IDLE, then resumes
// - Both registers write-only; reads give undefined data
// - Disable or clear before STOP, clear after
// - Clear before disabling inside watchdog interrupt handler
// - Set stack pointer before choosing interrupt action
// - Setup bits: enable 3, period 2:1, action 0
`timescale 1ns/1ps
`default_nettype none
module wdt_core
   import wdt_pkg::*;
#(
   parameter int EXP_BASE = PER_EXP_BASE
) (
   input wire logic core_clk,
   input wire logic rst,
   wdt_if.device bus,
   input wire logic prescale_double_sel,
   output logic watchdog_running
);
   import wdt_pkg::*;
   // Divider plus binary counter; longest period uses 2^(EXP_BASE+1)
   localparam int TOT_W = EXP_BASE + 1;
   localparam int DIV_W = TOT_W - BIN_STAGES;
   initial
   begin
      if (EXP_BASE < 3 * PER_EXP_STEP + BIN_STAGES + 1) $error("EXP_BASE too small");
   end

   logic wdog_run_enable_q, wdog_run_enable_d;
   logic [1:0] detect_period_sel_q, detect_period_sel_d;
   logic overflow_action_sel_q, overflow_action_sel_d;
   logic disabled_q, disabled_d;
   logic [DIV_W-1:0] div_q, div_d;
   logic [BIN_STAGES-1:0] bin_q, bin_d;
   logic [DIV_W-1:0] div_prev_q, div_prev_d;
   logic nmi_q, nmi_d;
   logic [7:0] pend_q, pend_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic ovf;
   logic tap_now, tap_prev;
   int tap_idx;
   logic wr_setup, wr_key;

   assign wr_setup = bus.wr && bus.addr == SETUP_OFFSET;
   assign wr_key = bus.wr && bus.addr == KEY_OFFSET;

   // Binary counter advances on each falling edge of the selected divider tap
   always_comb
   begin
      tap_idx = EXP_BASE - BIN_STAGES - PER_EXP_STEP * int'(detect_period_sel_q)
         + int'(prescale_double_sel) - 1;
      tap_now = div_q[tap_idx];
      tap_prev = div_prev_q[tap_idx];
   end

   always_comb
   begin
      wdog_run_enable_d = wdog_run_enable_q;
      detect_period_sel_d = detect_period_sel_q;
      overflow_action_sel_d = overflow_action_sel_q;
      disabled_d = disabled_q;
      div_d = div_q;
      div_prev_d = div_q;
      bin_d = bin_q;
      ovf = 1'b0;
      if (wr_setup)
      begin
         wdog_run_enable_d = bus.wdata[EN_BIT];
         detect_period_sel_d = bus.wdata[PER_LSB +: 2];
         if (bus.wdata[EN_BIT])
            disabled_d = 1'b0;
         // Only a move toward interrupt takes effect
         overflow_action_sel_d = overflow_action_sel_q & bus.wdata[ACT_BIT];
      end
      if (disabled_q)
      begin
         div_d = '0;
         div_prev_d = '0;
         bin_d = '0;
      end
      else if (!bus.hold)
      begin
         div_d = div_q + 1'b1;
         if (tap_prev && !tap_now)
         begin
            {ovf, bin_d} = {1'b0, bin_q} + 1'b1;
         end
      end
      else
         div_prev_d = div_prev_q;
      if (wr_key)
      begin
         if (bus.wdata == CLEAR_CODE)
            bin_d = '0;
         else if (bus.wdata == DISABLE_CODE && !wdog_run_enable_q)
            disabled_d = 1'b1;
         // Any other value is ignored
      end
   end

   // Stack of pending watchdog interrupts; newest served first
   always_comb
   begin
      nmi_d = nmi_q;
      pend_d = pend_q;
      if (ovf && overflow_action_sel_q == ACT_NMI)
      begin
         // Ignores the master flag by design; an active one is pushed pending
         nmi_d = 1'b1;
         if (nmi_q && !bus.nmi_ack && pend_q != 8'hFF)
            pend_d = pend_q + 1'b1;
      end
      else if (bus.nmi_ack)
      begin
         if (pend_q != '0)
            pend_d = pend_q - 1'b1;
         else
            nmi_d = 1'b0;
      end
   end

   // Registers are write-only; a read returns filler
   always_comb
   begin
      rdata_d = UNDEF_READ;
   end

   wdt_pulse_stretch #(
      .LEN(RESET_CYCLES)
   ) u_rst_pulse (
      .core_clk(core_clk),
      .rst(rst),
      .trig(ovf && overflow_action_sel_q == ACT_RESET),
      .pulse(bus.reset_request)
   );

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         wdog_run_enable_q <= SETUP_RESET[EN_BIT];
         detect_period_sel_q <= SETUP_RESET[PER_LSB +: 2];
         overflow_action_sel_q <= SETUP_RESET[ACT_BIT];
         disabled_q <= 1'b0;
         div_q <= '0;
         div_prev_q <= '0;
         bin_q <= '0;
         nmi_q <= 1'b0;
         pend_q <= '0;
         rdata_q <= UNDEF_READ;
      end
      else
      begin
         wdog_run_enable_q <= wdog_run_enable_d;
         detect_period_sel_q <= detect_period_sel_d;
         overflow_action_sel_q <= overflow_action_sel_d;
         disabled_q <= disabled_d;
         div_q <= div_d;
         div_prev_q <= div_prev_d;
         bin_q <= bin_d;
         nmi_q <= nmi_d;
         pend_q <= pend_d;
         rdata_q <= rdata_d;
      end
   end

   assign bus.rdata = rdata_q;
   assign bus.watchdog_nmi_request = nmi_q;
   assign watchdog_running = !disabled_q;
endmodule : wdt_core
`default_nettype wire

// ===== test/wdt_monitor.sv
// Checker: watchdog overflow actions, pause and disable on the shared interface
`timescale 1ns/1ps
`default_nettype none
module wdt_monitor
   import wdt_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic hold,
   input wire logic irq_master_flag,
   input wire logic watchdog_nmi_request,
   input wire logic nmi_ack,
   input wire logic reset_request
);
   logic act_q, act_d, en_q, en_d, dis_q, dis_d;
   logic [7:0] len_q, len_d;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // Shadow of the write-only setup bits, since they cannot be read back
   always_comb
   begin
      act_d = act_q;
      en_d = en_q;
      dis_d = dis_q;
      len_d = reset_request ? len_q + 8'h01 : 8'h00;
      if (wr && addr == SETUP_OFFSET)
      begin
         if (wdata[ACT_BIT] == ACT_NMI)
            act_d = ACT_NMI;
         en_d = wdata[EN_BIT];
         if (wdata[EN_BIT])
            dis_d = 1'b0;
      end
      if (wr && addr == KEY_OFFSET && wdata == DISABLE_CODE && !en_q)
         dis_d = 1'b1;
   end
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         act_q <= ACT_RESET;
         en_q <= 1'b1;
         dis_q <= 1'b0;
         len_q <= 8'h00;
      end
      else
      begin
         act_q <= act_d;
         en_q <= en_d;
         dis_q <= dis_d;
         len_q <= len_d;
      end
   end
   a_reset_len: assert property (len_q <= RESET_CYCLES)
      else $error("reset request held too long");
   a_rst_cause: assert property ($rose(reset_request) |-> $past(act_q) == ACT_RESET)
      else $error("reset request while interrupt action chosen");
   a_nmi_cause: assert property ($rose(watchdog_nmi_request) |-> $past(act_q) == ACT_NMI)
      else $error("interrupt request while reset action chosen");
   a_nmi_holds: assert property (watchdog_nmi_request && !nmi_ack |=> watchdog_nmi_request)
      else $error("interrupt request dropped without service");
   a_rdata_undef: assert property (rdata == UNDEF_READ)
      else $error("write-only register returned data");
   a_hold_freeze: assert property (hold && $past(hold) |-> !$rose(reset_request)
      && !$rose(watchdog_nmi_request))
      else $error("overflow during pause");
   a_disable_quiet: assert property (dis_q && $past(dis_q) |-> !$rose(reset_request)
      && !$rose(watchdog_nmi_request))
      else $error("overflow while disabled");
   a_rst_quiet: assert property ($fell(rst) |-> !reset_request && !watchdog_nmi_request)
      else $error("request active at reset release");
   a_mask_disable: assert property (wr && addr == KEY_OFFSET && wdata == DISABLE_CODE
      |-> !irq_master_flag)
      else $error("disable code written while interrupts enabled");
   c_reset: cover property ($rose(reset_request));
   c_nmi: cover property ($rose(watchdog_nmi_request));
   c_disabled: cover property ($rose(dis_q));
endmodule : wdt_monitor
`default_nettype wire

// ===== test/watchdog_reset_nmi_timer_test.sv
// Testbench: both watchdog ends joined, driven from the software port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
   begin \
      comparisons++; \
      if ((a) !== (e)) \
      begin \
         fails++; \
         $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); \
      end \
   end
module watchdog_reset_nmi_timer_test;
   import wdt_pkg::*;
   // Short periods keep the run small: code 00 is 2^10 cycles
   localparam int EB = 10;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] sw_addr = '0;
   logic [DATA_W-1:0] sw_wdata = '0;
   logic sw_wr = 1'b0;
   logic sw_rd = 1'b0;
   logic cpu_hold = 1'b0;
   logic done_p = 1'b0;
   logic dbl = 1'b0;
   logic rd_q = 1'b0;
   logic [2:0] exp_s;
   logic [DATA_W-1:0] sw_rdata;
   logic cpu_reset;
   logic running;
   logic [2:0] notes[$];
   int fails = 0;
   int comparisons = 0;
   int n;
   int per;
   wdt_if bus_if();
   always #2.5 core_clk = ~core_clk;
   wdt_core #(.EXP_BASE(EB)) u_wdt_core (.core_clk(core_clk), .rst(rst), .bus(bus_if.device),
      .prescale_double_sel(dbl), .watchdog_running(running));
   wdt_ctrl u_wdt_ctrl (.core_clk(core_clk), .rst(rst), .bus(bus_if.host), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
      .cpu_hold(cpu_hold), .nmi_service_done(done_p), .cpu_reset(cpu_reset));
   wdt_monitor u_wdt_monitor (.core_clk(core_clk), .rst(rst), .addr(bus_if.addr),
      .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata),
      .hold(bus_if.hold), .irq_master_flag(bus_if.irq_master_flag),
      .watchdog_nmi_request(bus_if.watchdog_nmi_request), .nmi_ack(bus_if.nmi_ack),
      .reset_request(bus_if.reset_request));
   always @(posedge core_clk)
   begin
      rd_q <= sw_rd;
      if (rd_q && notes.size() > 0)
      begin
         exp_s = notes.pop_front();
         `CHK(sw_rdata[2:0], exp_s)
      end
   end
   task automatic tally_and_finish;
      if (fails == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish
   // Settled sampling happens on the falling edge
   task automatic tick(input int k);
      repeat (k) @(negedge core_clk);
   endtask : tick
   task automatic do_reset;
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
   endtask : do_reset
   task automatic cmd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge core_clk);
      sw_wr <= 1'b0;
      tick(2);
   endtask : cmd
   task automatic status(input logic [2:0] e);
      notes.push_back(e);
      @(posedge core_clk);
      sw_addr <= CMD_STATUS;
      sw_rd <= 1'b1;
      @(posedge core_clk);
      sw_rd <= 1'b0;
      tick(2);
   endtask : status
   task automatic ack;
      @(posedge core_clk);
      done_p <= 1'b1;
      @(posedge core_clk);
      done_p <= 1'b0;
      tick(3);
   endtask : ack
   task automatic wait_hi(input logic sel, input int lim);
      n = 0;
      while ((sel ? cpu_reset : bus_if.watchdog_nmi_request) !== 1'b1)
      begin
         tick(1);
         n++;
         if (n > lim)
         begin
            fails++;
            tally_and_finish();
         end
      end
   endtask : wait_hi
   initial
   begin
      void'($urandom(32'h5A167DBB));
      do_reset();
      status(3'b001);
      `CHK(running, 1'b1)
      wait_hi(1'b1, 1100);
      `CHK(n >= 760 && n <= 1030, 1'b1)
      n = 0;
      while (cpu_reset === 1'b1 && n < 40)
      begin
         tick(1);
         n++;
      end
      `CHK(n, RESET_CYCLES)
      do_reset();
      cmd(CMD_ACTION, 8'h00);
      // Every period code, then the doubled shortest one
      for (int c = 0; c < 5; c++)
      begin
         @(posedge core_clk);
         dbl <= (c == 4);
         cmd(CMD_CLEAR, 8'h00);
         cmd(CMD_PERIOD, {6'($urandom), 2'(c == 4 ? 3 : c)});
         cmd(CMD_CLEAR, 8'h00);
         per = 1 << (EB - 2 * (c == 4 ? 3 : c) + int'(c == 4));
         wait_hi(1'b0, 2 * per);
         `CHK(n >= per * 3 / 4 - 2 && n <= per + 3, 1'b1)
         `CHK(cpu_reset, 1'b0)
         ack();
         `CHK(bus_if.watchdog_nmi_request, 1'b0)
      end
      @(posedge core_clk);
      dbl <= 1'b0;
      cmd(CMD_CLEAR, 8'h00);
      wait_hi(1'b0, 40);
      tick(20);
      @(posedge core_clk);
      cpu_hold <= 1'b1;
      ack();
      `CHK(bus_if.watchdog_nmi_request, 1'b1)
      ack();
      `CHK(bus_if.watchdog_nmi_request, 1'b0)
      tick(60);
      `CHK(bus_if.watchdog_nmi_request, 1'b0)
      @(posedge core_clk);
      cpu_hold <= 1'b0;
      wait_hi(1'b0, 40);
      `CHK(n <= 15, 1'b1)
      ack();
      repeat (12)
      begin
         cmd(CMD_CLEAR, 8'h00);
         tick($urandom_range(0, 4));
      end
      `CHK(bus_if.watchdog_nmi_request, 1'b0)
      cmd(CMD_ACTION, 8'h01);
      wait_hi(1'b0, 40);
      `CHK(cpu_reset, 1'b0)
      ack();
      cmd(CMD_DISABLE, 8'h00);
      tick(8);
      status(3'b000);
      `CHK(running, 1'b0)
      tick(100);
      `CHK(bus_if.watchdog_nmi_request, 1'b0)
      cmd(CMD_ENABLE, 8'h00);
      status(3'b001);
      wait_hi(1'b0, 40);
      `CHK(n >= 8, 1'b1)
      tick(4);
      tally_and_finish();
   end
endmodule : watchdog_reset_nmi_timer_test
`default_nettype wire
